// File: hw/phy_quad_rx.sv
// Receive end: pairs two quadlets and checks that the second inverts the first.
`timescale 1ns/100ps
module phy_quad_rx (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [31:0] rx_data,
   input  wire logic        rx_valid,
   quad_if.src              pair
);
   logic [31:0] first;
   logic        have_first;

   // =====================================================================
   // Pairing; a pair is offered and held until it is accepted by the reader.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         first      <= 32'h0;
         have_first <= 1'b0;
         pair.quad  <= 32'h0;
         pair.good  <= 1'b0;
         pair.valid <= 1'b0;
      end else if (ce) begin
         if (pair.valid && pair.ready) begin
            pair.valid <= 1'b0;
         end
         if (rx_valid && !have_first) begin
            first      <= rx_data;
            have_first <= 1'b1;
         end else if (rx_valid) begin
            pair.quad  <= first;
            pair.good  <= (rx_data == ~first);
            pair.valid <= 1'b1;
            have_first <= 1'b0;
         end
      end
   end
endmodule : phy_quad_rx

// File: hw/phy_quad_tx.sv
// Transmit end: sends a first quadlet and then its bitwise inverse.
`timescale 1ns/100ps
module phy_quad_tx (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        ce,
   quad_if.snk              pkt,
   output logic [31:0]      tx_data,
   output logic             tx_valid,
   input  wire logic        tx_ready
);
   logic second;

   // A new packet is taken only when nothing is in flight.
   assign pkt.ready = !tx_valid;

   // =====================================================================
   // Quadlet sequencing; the inverse is made here so software never writes it.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_data  <= 32'h0;
         tx_valid <= 1'b0;
         second   <= 1'b0;
      end else if (ce) begin
         if (pkt.valid && pkt.ready) begin
            tx_data  <= pkt.quad;
            tx_valid <= 1'b1;
            second   <= 1'b0;
         end else if (tx_valid && tx_ready) begin
            if (!second) begin
               tx_data <= ~tx_data;
               second  <= 1'b1;
            end else begin
               tx_valid <= 1'b0;
               second   <= 1'b0;
            end
         end
      end
   end
endmodule : phy_quad_tx

// File: hw/quad_if.sv
// Quadlet hand-off between the packet block and its transmit and receive ends.
`timescale 1ns/100ps
interface quad_if;
   logic [31:0] quad;
   logic        good;
   logic        valid;
   logic        ready;
   modport src (output quad, output good, output valid, input ready);
   modport snk (input quad, input good, input valid, output ready);
endinterface : quad_if

// File: hw/remote_phy_command_packets.sv
// Remote PHY command, resume and confirmation packet framer with register port.
`timescale 1ns/100ps
module remote_phy_command_packets (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic [31:0]      rdata,
   output logic [31:0]      tx_data,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   input  wire logic [31:0] rx_data,
   input  wire logic        rx_valid,
   input  wire logic [4:0]  rx_ack_code,
   input  wire logic [1:0]  rx_speed
);
   typedef enum logic {st_idle, st_offer} tx_state_t;

   tx_state_t                         tx_state;
   logic [31:0]                       offer_quad;
   logic                              offer_resume;
   logic [rpcp_pkg::NODE_W-1:0]       local_id;
   logic [31:0]                       conf_q;
   logic [31:0]                       token;
   logic                              conf_valid;
   logic                              discard;
   logic                              refused;
   logic [4:0]                        ack_hold;
   logic [1:0]                        speed_hold;
   logic                              tx_second;

   quad_if tx_if ();
   quad_if rx_if ();

   // =====================================================================
   // Transmit and receive ends.
   phy_quad_tx u_tx (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .ce       (ce),
      .pkt      (tx_if.snk),
      .tx_data  (tx_data),
      .tx_valid (tx_valid),
      .tx_ready (tx_ready)
   );

   phy_quad_rx u_rx (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .ce       (ce),
      .rx_data  (rx_data),
      .rx_valid (rx_valid),
      .pair     (rx_if.src)
   );

   // =====================================================================
   // Register decode. All strobes are ignored while the clock enable is low.
   wire is_wr_cmd    = ce && wr_stb && (addr == rpcp_pkg::ADDR_TX_CMD);
   wire is_wr_resume = ce && wr_stb && (addr == rpcp_pkg::ADDR_TX_RESUME);
   wire is_wr_id     = ce && wr_stb && (addr == rpcp_pkg::ADDR_LOCAL_ID);
   wire is_wr_status = ce && wr_stb && (addr == rpcp_pkg::ADDR_STATUS);
   wire busy         = (tx_state != st_idle) || tx_valid;
   wire launch_req   = is_wr_cmd || is_wr_resume;
   wire launch       = launch_req && !busy;

   // =====================================================================
   // First quadlet of a command: destination node, type, page, port, code.
   wire [rpcp_pkg::NODE_W-1:0] wr_node = wdata[rpcp_pkg::WR_NODE +: rpcp_pkg::NODE_W];
   wire [rpcp_pkg::PAGE_W-1:0] wr_page = wdata[rpcp_pkg::WR_PAGE +: rpcp_pkg::PAGE_W];
   wire [rpcp_pkg::PORT_W-1:0] wr_port = wdata[rpcp_pkg::WR_PORT +: rpcp_pkg::PORT_W];
   wire [rpcp_pkg::CODE_W-1:0] wr_code = wdata[rpcp_pkg::WR_CODE +: rpcp_pkg::CODE_W];

   wire [31:0] cmd_quad = {rpcp_pkg::PKT_ID,
                           wr_node,
                           2'h0,
                           rpcp_pkg::TYPE_CMD,
                           wr_page,
                           wr_port,
                           8'h00,
                           wr_code};

   // Resume names the sender and has no destination, so every node hears it.
   wire [31:0] resume_quad = {rpcp_pkg::PKT_ID,
                              local_id,
                              2'h0,
                              rpcp_pkg::TYPE_RESUME,
                              18'h00000};

   assign tx_if.quad  = offer_quad;
   assign tx_if.good  = 1'b1;
   assign tx_if.valid = (tx_state == st_offer);

   // =====================================================================
   // Transmit launch. A write while busy is dropped and flagged, since the
   // register port can never be stalled.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_state     <= st_idle;
         offer_quad   <= 32'h0;
         offer_resume <= 1'b0;
      end else if (ce) begin
         unique case (tx_state)
            st_idle: begin
               if (launch) begin
                  offer_quad   <= is_wr_cmd ? cmd_quad : resume_quad;
                  offer_resume <= is_wr_resume;
                  tx_state     <= st_offer;
               end
            end
            st_offer: begin
               if (tx_if.ready) begin
                  tx_state <= st_idle;
               end
            end
         endcase
      end
   end

   // =====================================================================
   // Own node identifier, used as the source of resume packets.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         local_id <= '0;
      end else if (is_wr_id) begin
         local_id <= wdata[rpcp_pkg::WR_NODE +: rpcp_pkg::NODE_W];
      end
   end

   // =====================================================================
   // Receive side. Acknowledge and speed arrive beside each quadlet; the
   // values seen with the second quadlet are the ones kept.
   assign rx_if.ready = ce;

   wire conf_hdr  = (rx_if.quad[rpcp_pkg::Q_PID +: 2] == rpcp_pkg::PKT_ID) &&
                    (rx_if.quad[rpcp_pkg::Q_TYPE +: 4] == rpcp_pkg::TYPE_CONF);
   wire conf_take = ce && rx_if.valid && rx_if.good && conf_hdr;
   wire conf_bad  = ce && rx_if.valid && !rx_if.good;

   // Control token of a PHY packet: two quadlets, PHY flag set, no padding.
   wire [31:0] next_token = {2'h0,
                             rpcp_pkg::PHY_PKT_QUADS,
                             1'b0,
                             1'b1,
                             1'b0,
                             ack_hold,
                             rpcp_pkg::PHY_PKT_PAD,
                             speed_hold,
                             4'h0};

   // Acknowledge and speed follow every quadlet, so the pair's second one wins.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_hold   <= 5'h00;
         speed_hold <= 2'h0;
      end else if (ce && rx_valid) begin
         ack_hold   <= rx_ack_code;
         speed_hold <= rx_speed;
      end
   end

   // =====================================================================
   // Confirmation capture. A mismatched pair is dropped and flagged.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         conf_q <= 32'h0;
         token  <= 32'h0;
      end else if (conf_take) begin
         conf_q <= rx_if.quad;
         token  <= next_token;
      end
   end

   // =====================================================================
   // Sticky flags. Hardware setting wins over a software clear in one cycle.
   wire clr_conf    = is_wr_status && wdata[rpcp_pkg::ST_CONF];
   wire clr_discard = is_wr_status && wdata[rpcp_pkg::ST_DISCARD];
   wire clr_refused = is_wr_status && wdata[rpcp_pkg::ST_REFUSED];
   wire set_refused = launch_req && busy;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         conf_valid <= 1'b0;
         discard    <= 1'b0;
         refused    <= 1'b0;
      end else begin
         conf_valid <= conf_take || (conf_valid && !clr_conf);
         discard    <= conf_bad || (discard && !clr_discard);
         refused    <= set_refused || (refused && !clr_refused);
      end
   end

   // =====================================================================
   // Read view. Status shows the last confirmation's port, state and code.
   wire [31:0] status_word = {16'h0000,
                              refused,
                              conf_q[rpcp_pkg::Q_CODE +: rpcp_pkg::CODE_W],
                              conf_q[rpcp_pkg::Q_PORT +: rpcp_pkg::PORT_W],
                              conf_q[rpcp_pkg::Q_FAULT],
                              conf_q[rpcp_pkg::Q_CONN],
                              conf_q[rpcp_pkg::Q_BIAS],
                              conf_q[rpcp_pkg::Q_DIS],
                              conf_q[rpcp_pkg::Q_OK],
                              discard,
                              conf_valid,
                              busy};

   wire [31:0] id_word = {{(32 - rpcp_pkg::NODE_W){1'b0}}, local_id};

   wire [31:0] read_mux = (addr == rpcp_pkg::ADDR_LOCAL_ID) ? id_word     :
                          (addr == rpcp_pkg::ADDR_STATUS)   ? status_word :
                          (addr == rpcp_pkg::ADDR_TOKEN)    ? token       :
                          (addr == rpcp_pkg::ADDR_CONF)     ? conf_q      :
                                                              32'h0;

   // Read data stand for exactly the cycle after the strobe.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0;
      end else if (ce) begin
         rdata <= rd_stb ? read_mux : 32'h0;
      end
   end

   // =====================================================================
   // Checking helpers: which quadlet of the outgoing pair is on the wire.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_second <= 1'b0;
      end else if (ce && tx_valid && tx_ready) begin
         tx_second <= !tx_second;
      end
   end

   // =====================================================================
   // Checks on the framer's own outputs and stored state.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // A written command shows up field for field in the offered quadlet.
   cmd_fields_a: assert property (
      (tx_state == st_idle && launch && is_wr_cmd) |=>
         (tx_if.quad[rpcp_pkg::Q_NODE +: rpcp_pkg::NODE_W] == $past(wr_node)) &&
         (tx_if.quad[rpcp_pkg::Q_PAGE +: rpcp_pkg::PAGE_W] == $past(wr_page)) &&
         (tx_if.quad[rpcp_pkg::Q_PORT +: rpcp_pkg::PORT_W] == $past(wr_port)) &&
         (tx_if.quad[rpcp_pkg::Q_CODE +: rpcp_pkg::CODE_W] == $past(wr_code)))
      else $error("Command fields differ from the written values.");

   // Every offered command carries the zero identifier and the command type.
   cmd_type_a: assert property (
      (tx_if.valid && !offer_resume) |->
         (tx_if.quad[31:30] == rpcp_pkg::PKT_ID) && (tx_if.quad[21:18] == rpcp_pkg::TYPE_CMD))
      else $error("Command packet header is wrong.");

   // A resume names this node as sender and leaves all lower bits clear.
   resume_hdr_a: assert property (
      (tx_state == st_idle && launch && is_wr_resume) |=>
         tx_if.valid && (tx_if.quad[21:18] == rpcp_pkg::TYPE_RESUME) &&
         (tx_if.quad[29:24] == $past(local_id)) && (tx_if.quad[17:0] == 18'h00000))
      else $error("Resume packet header is wrong.");

   // The second quadlet on the wire is the exact inverse of the first.
   tx_inverse_a: assert property (
      (ce && tx_valid && tx_ready && !tx_second) |=>
         tx_valid && (tx_data == ~$past(tx_data)))
      else $error("Second quadlet is not the inverse of the first.");

   // An offer must wait unchanged until the transmit end takes it.
   offer_hold_a: assert property (
      (tx_if.valid && !tx_if.ready) |=> tx_if.valid && $stable(tx_if.quad))
      else $error("Offered packet dropped before the transmitter took it.");

   // The token of a kept confirmation reflects the pair just received.
   conf_token_a: assert property (
      conf_take |=>
         (token[29:16] == rpcp_pkg::PHY_PKT_QUADS) && !token[15] && token[14] &&
         (token[12:8] == $past(ack_hold)) && (token[5:4] == $past(speed_hold)) &&
         (token[7:6] == rpcp_pkg::PHY_PKT_PAD))
      else $error("Control token does not match the received packet.");

   // A kept confirmation is stored whole and flagged.
   conf_seen_a: assert property (
      conf_take |=> conf_valid && (conf_q == $past(rx_if.quad)))
      else $error("Confirmation was not captured.");

   // A broken pair only raises the discard flag.
   bad_pair_a: assert property (
      conf_bad |=> discard && $stable(conf_q) && $stable(token))
      else $error("Mismatched confirmation was not discarded.");

   // Whatever the launch offered is the first quadlet sent.
   first_quad_a: assert property (
      $rose(tx_valid) |-> (tx_data == $past(offer_quad)))
      else $error("First quadlet differs from the offered packet.");

   // A packet ends after exactly two accepted quadlets.
   pair_end_a: assert property (
      (ce && tx_valid && tx_ready && tx_second) |=> !tx_valid)
      else $error("Transmitter kept sending after the inverse quadlet.");

   // The pair verdict must match the two quadlets that formed it.
   pair_check_a: assert property (
      $rose(rx_if.valid) |-> (rx_if.good == (rx_if.quad == ~$past(rx_data))))
      else $error("Pair check disagrees with the received quadlets.");

   // Stored confirmation and token change only on a kept confirmation.
   conf_hold_a: assert property (
      !conf_take |=> $stable(conf_q) && $stable(token))
      else $error("Stored confirmation changed without a new one.");

   // A launch while busy leaves the packet in flight alone and is flagged.
   busy_guard_a: assert property (
      (launch_req && busy) |=> refused && $stable(offer_quad))
      else $error("Launch while busy disturbed the outgoing packet.");

endmodule : remote_phy_command_packets

// File: hw/rpcp_pkg.sv
// Constants, field layouts and register offsets of the remote PHY packet block.
package rpcp_pkg;
   // =====================================================================
   // Register offsets on the plain register port.
   localparam logic [7:0] ADDR_TX_CMD    = 8'h00;
   localparam logic [7:0] ADDR_TX_RESUME = 8'h04;
   localparam logic [7:0] ADDR_LOCAL_ID  = 8'h08;
   localparam logic [7:0] ADDR_STATUS    = 8'h0C;
   localparam logic [7:0] ADDR_TOKEN     = 8'h10;
   localparam logic [7:0] ADDR_CONF      = 8'h14;

   // =====================================================================
   // Field widths and positions in the first quadlet of a PHY packet.
   localparam int NODE_W  = 6;
   localparam int PAGE_W  = 3;
   localparam int PORT_W  = 4;
   localparam int CODE_W  = 3;
   localparam int Q_PID   = 30;
   localparam int Q_NODE  = 24;
   localparam int Q_TYPE  = 18;
   localparam int Q_PAGE  = 15;
   localparam int Q_PORT  = 11;
   localparam int Q_FAULT = 7;
   localparam int Q_CONN  = 6;
   localparam int Q_BIAS  = 5;
   localparam int Q_DIS   = 4;
   localparam int Q_OK    = 3;
   localparam int Q_CODE  = 0;
   localparam logic [1:0] PKT_ID      = 2'h0;
   localparam logic [3:0] TYPE_CMD    = 4'h8;
   localparam logic [3:0] TYPE_CONF   = 4'hA;
   localparam logic [3:0] TYPE_RESUME = 4'hF;

   // =====================================================================
   // Write data layout of the command register.
   localparam int WR_NODE = 0;
   localparam int WR_PAGE = 8;
   localparam int WR_PORT = 12;
   localparam int WR_CODE = 16;

   // =====================================================================
   // Status register bits; the clear bits are write-one-to-clear.
   localparam int ST_BUSY    = 0;
   localparam int ST_CONF    = 1;
   localparam int ST_DISCARD = 2;
   localparam int ST_REFUSED = 15;

   // =====================================================================
   // Receive control token contents for a PHY packet.
   localparam logic [13:0] PHY_PKT_QUADS = 14'h0002;
   localparam logic [1:0]  PHY_PKT_PAD   = 2'h0;

   typedef enum logic [2:0] {
      code_nop     = 3'h0,
      code_disable = 3'h1,
      code_suspend = 3'h2,
      code_clr_flt = 3'h4,
      code_enable  = 3'h5,
      code_resume  = 3'h6
   } cmd_code_t;

   typedef enum logic [1:0] {
      spd_100 = 2'h0,
      spd_200 = 2'h1,
      spd_400 = 2'h2,
      spd_undef = 2'h3
   } speed_t;
endpackage : rpcp_pkg

// File: testbench/phy_link_model.sv
// Local PHY model: takes transmitted quadlets and delivers received quadlet pairs.
`timescale 1ns/100ps
module phy_link_model (
   input  wire logic        clk_sys,
   input  wire logic [31:0] tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic [31:0]      rx_data,
   output logic             rx_valid,
   output logic [4:0]       rx_ack_code,
   output logic [1:0]       rx_speed
);
   // ==========================================================================
   // Transmit side.
   logic [31:0] got[$];
   logic        slow;

   initial begin
      slow        = 1'h0;
      tx_ready    = 1'h0;
      rx_valid    = 1'h0;
      rx_data     = 32'h0000_0000;
      rx_ack_code = 5'h00;
      rx_speed    = 2'h0;
   end

   // Slow mode grants only every other cycle, so the sender has to hold its quadlet.
   always @(posedge clk_sys) begin
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
      tx_ready <= slow ? ~tx_ready : 1'h1;
   end

   // ==========================================================================
   // Receive side.
   // Answers the last command seen; an idle data line shows a changed pattern, not the old quadlet.
   // The st argument carries fault, connected, bias, disabled and accepted, top bit first.
   task automatic reply(input logic [4:0] st, input logic [4:0] ack, input logic [1:0] spd,
                        input logic [3:0] typ, input logic bad);
      logic [31:0] cmd;
      logic [31:0] q;
      cmd = got[got.size() - 2];
      q   = {2'h0, cmd[29:24], 2'h0, typ, 3'h0, cmd[14:11], 3'h0, st, cmd[2:0]};
      @(posedge clk_sys);
      rx_valid    <= 1'h1;
      rx_data     <= q;
      rx_ack_code <= ack;
      rx_speed    <= spd;
      @(posedge clk_sys);
      rx_data <= bad ? ~q ^ 32'h0000_0100 : ~q;
      @(posedge clk_sys);
      rx_valid <= 1'h0;
      rx_data  <= q ^ 32'h5A5A_5A5A;
   endtask : reply
endmodule : phy_link_model

// File: testbench/remote_phy_command_packets_tb.sv
// Self-checking bench for the remote PHY command and confirmation packet block.
`timescale 1ns/100ps
module remote_phy_command_packets_tb;
   logic        clk_sys, rst_n, ce, wr_stb, rd_stb, tx_valid, tx_ready, rx_valid;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, tx_data, rx_data, v, q, conf;
   logic [4:0]  rx_ack_code;
   logic [1:0]  rx_speed;
   int          mismatches, checks;
   localparam logic [7:0] idle_a[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
   localparam rpcp_pkg::cmd_code_t codes[6] = '{rpcp_pkg::code_nop, rpcp_pkg::code_disable,
      rpcp_pkg::code_suspend, rpcp_pkg::code_clr_flt, rpcp_pkg::code_enable, rpcp_pkg::code_resume};

   remote_phy_command_packets u_remote_phy_command_packets (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ack_code(rx_ack_code), .rx_speed(rx_speed));
   phy_link_model u_phy_link_model (.clk_sys(clk_sys), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ack_code(rx_ack_code),
      .rx_speed(rx_speed));

   // ==========================================================================
   // Clock and shared tasks.
   always #10 clk_sys = ~clk_sys;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'h1;
      @(posedge clk_sys);
      wr_stb <= 1'h0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      @(posedge clk_sys);
      addr   <= a;
      rd_stb <= 1'h1;
      @(posedge clk_sys);
      rd_stb <= 1'h0;
      #1;
      v = rdata;
      check(v & mask, exp);
   endtask : rc

   // Bounded wait for the model to hold n quadlets, then let busy drop.
   task automatic wait_tx(input int n);
      for (int i = 0; i < 300 && u_phy_link_model.got.size() < n; i++)
         @(posedge clk_sys);
      repeat (3) @(posedge clk_sys);
      check(32'(u_phy_link_model.got.size()), 32'(n));
   endtask : wait_tx

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   // ==========================================================================
   // Watchdog: the tests need well under a thousand cycles.
   initial begin
      #100000;
      mismatches++;
      give_verdict();
   end

   // ==========================================================================
   // Test sequence.
   initial begin
      logic [5:0] node;
      logic [2:0] page;
      logic [3:0] port;
      logic [4:0] ack, st;
      clk_sys = 1'h0;
      rst_n   = 1'h0;
      ce      = 1'h1;
      addr    = 8'h00;
      wdata   = 32'h0000_0000;
      wr_stb  = 1'h0;
      rd_stb  = 1'h0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'h1;
      foreach (idle_a[i]) rc(idle_a[i], 32'hFFFF_FFFF, 32'h0000_0000);
      $display("test reset done");
      // Every command code with boundary fields, each answered by a confirmation.
      for (int k = 0; k < 6; k++) begin
         node = 6'(63 - k * 9);
         page = 3'(k + 2);
         port = 4'(k * 3);
         st   = 5'(k * 7 + 9);
         ack  = 5'(k * 5 + 1);
         q    = {2'h0, node, 2'h0, 4'h8, page, port, 8'h00, codes[k]};
         u_phy_link_model.slow <= k[0];
         wr(rpcp_pkg::ADDR_TX_CMD, {13'h0000, codes[k], port, 1'h0, page, 2'h0, node});
         wait_tx(2 * k + 2);
         check(u_phy_link_model.got[2 * k], q);
         check(u_phy_link_model.got[2 * k + 1], ~q);
         u_phy_link_model.reply(st, ack, 2'(k), 4'hA, 1'h0);
         repeat (4) @(posedge clk_sys);
         conf = {2'h0, node, 2'h0, 4'hA, 3'h0, port, 3'h0, st, codes[k]};
         rc(rpcp_pkg::ADDR_CONF, 32'hFFFF_FFFF, conf);
         rc(rpcp_pkg::ADDR_TOKEN, 32'hFFFF_FFFF, {16'h0002, 3'h2, ack, 2'h0, 2'(k), 4'h0});
         rc(rpcp_pkg::ADDR_STATUS, 32'hFFFF_FFFF, {17'h00000, codes[k], port, st, 3'h2});
         wr(rpcp_pkg::ADDR_STATUS, 32'h0000_0002);
      end
      $display("test commands done");
      // A launch while a packet is still going out is refused and sends nothing.
      u_phy_link_model.slow <= 1'h1;
      wr(rpcp_pkg::ADDR_TX_CMD, 32'h0001_2301);
      wr(rpcp_pkg::ADDR_TX_CMD, 32'h0005_0002);
      wait_tx(14);
      check(u_phy_link_model.got[12], 32'h0121_9001);
      check(u_phy_link_model.got[13], ~32'h0121_9001);
      rc(rpcp_pkg::ADDR_STATUS, 32'h0000_8001, 32'h0000_8000);
      wr(rpcp_pkg::ADDR_STATUS, 32'h0000_8000);
      rc(rpcp_pkg::ADDR_STATUS, 32'h0000_8000, 32'h0000_0000);
      $display("test refused done");
      // Own node number is kept to six bits and ignored while the clock enable is low.
      wr(rpcp_pkg::ADDR_LOCAL_ID, 32'hFFFF_FFEA);
      ce <= 1'h0;
      wr(rpcp_pkg::ADDR_LOCAL_ID, 32'h0000_0005);
      ce <= 1'h1;
      rc(rpcp_pkg::ADDR_LOCAL_ID, 32'hFFFF_FFFF, 32'h0000_002A);
      wr(rpcp_pkg::ADDR_TX_RESUME, 32'h0000_0000);
      wait_tx(16);
      check(u_phy_link_model.got[14], {10'h0A8, 4'hF, 18'h00000});
      check(u_phy_link_model.got[15], ~{10'h0A8, 4'hF, 18'h00000});
      $display("test resume done");
      // A broken pair is discarded and a wrong type is ignored; stored quadlet stays.
      conf = {2'h0, 6'h2A, 2'h0, 4'hA, 18'h00000};
      u_phy_link_model.reply(5'h07, 5'h1F, 2'h1, 4'hA, 1'h0);
      repeat (4) @(posedge clk_sys);
      rc(rpcp_pkg::ADDR_CONF, 32'hFFFF_FFFF, conf | 32'h0000_0038);
      u_phy_link_model.reply(5'h0B, 5'h02, 2'h2, 4'hA, 1'h1);
      repeat (4) @(posedge clk_sys);
      rc(rpcp_pkg::ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
      rc(rpcp_pkg::ADDR_CONF, 32'hFFFF_FFFF, conf | 32'h0000_0038);
      wr(rpcp_pkg::ADDR_STATUS, 32'h0000_0004);
      rc(rpcp_pkg::ADDR_STATUS, 32'h0000_0004, 32'h0000_0000);
      u_phy_link_model.reply(5'h0B, 5'h02, 2'h2, 4'h8, 1'h0);
      repeat (4) @(posedge clk_sys);
      rc(rpcp_pkg::ADDR_CONF, 32'hFFFF_FFFF, conf | 32'h0000_0038);
      $display("test receive faults done");
      give_verdict();
   end
endmodule : remote_phy_command_packets_tb
